// ===== hw/spi_flags_pkg.sv
// package for the serial status/flag block: register map, field layout, timing
// assumes: one 200 MHz clock, APB slave with 32-bit data
package spi_flags_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_STATUS = 8'h00;
  localparam logic [7:0] OFF_DATA = 8'h04;
  localparam logic [7:0] OFF_CTRL = 8'h08;
  localparam logic [7:0] OFF_EVSTAT = 8'h0C;
  localparam logic [7:0] OFF_EVMASK = 8'h10;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int BIT_DONE = 7;
  localparam int BIT_CLASH = 6;
  localparam int BIT_IRQEN = 0;
  localparam int BIT_MASTER = 1;
  localparam int EV_DONE = 0;
  localparam int EV_CLASH = 1;
  localparam logic [7:0] STATUS_RESET = 8'h80;
  localparam logic [1:0] CTRL_RESET = 2'h2;
  localparam logic [1:0] EV_RESET = 2'h0;

  // ----------------------------------------------------------------
  // timing: serial clock half period
  // ----------------------------------------------------------------
  localparam int CLOCK_MHZ = 200;
  localparam int SCK_HALF_NS = 10;
  localparam int SCK_HALF_CYC = (SCK_HALF_NS * CLOCK_MHZ + 999) / 1000;
  localparam int BITS_PER_BYTE = 8;

  // status register image
  typedef struct packed {
    logic done;
    logic clash;
    logic [5:0] rsvd;
  } status_s;

  // control register image
  typedef struct packed {
    logic master;
    logic irqEnable;
  } ctrl_s;

  // shift engine states
  typedef enum logic [1:0] {
    ENG_IDLE = 2'b01,
    ENG_SHIFT = 2'b10
  } eng_state_e;

endpackage : spi_flags_pkg

// ===== hw/byte_shifter.sv
// byte shift engine: exchanges one byte, mode 0, msb first
// assumes: start is a one-cycle pulse only taken while idle
`timescale 1ns/1ps
module byte_shifter
  import spi_flags_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // control side
  input wire logic start,
  input wire logic [7:0] txByte,
  output logic busy,
  output logic done,
  output logic [7:0] rxByte,
  // serial pins
  output logic sclk,
  output logic mosi,
  input wire logic miso
);

  localparam logic [4:0] HALF_LAST = 5'(2 * BITS_PER_BYTE - 1);
  localparam logic [7:0] HALF_CNT = 8'(SCK_HALF_CYC - 1);

  eng_state_e state_reg, state_next;
  logic [7:0] shift_reg, shift_next;
  logic [7:0] rx_reg, rx_next;
  logic [4:0] half_reg, half_next;
  logic [7:0] tick_reg, tick_next;
  logic sclk_reg, sclk_next;
  logic done_reg, done_next;
  logic misoBit_reg, misoBit_next;

  // next-state logic: each half period toggles sclk; sample on rise, shift on fall
  // mosi only moves at the start load and on the falling edge so the far side never sees it change at the rise
  always_comb begin
    state_next = state_reg;
    shift_next = shift_reg;
    misoBit_next = misoBit_reg;
    rx_next = rx_reg;
    half_next = half_reg;
    tick_next = tick_reg;
    sclk_next = sclk_reg;
    done_next = 1'b0;
    case (state_reg)
      ENG_IDLE: begin
        if (start) begin
          state_next = ENG_SHIFT;
          shift_next = txByte;
          half_next = 5'h0;
          tick_next = HALF_CNT;
          sclk_next = 1'b0;
        end
      end
      ENG_SHIFT: begin
        if (tick_reg != 8'h0) begin
          tick_next = tick_reg - 8'h1;
        end else begin
          tick_next = HALF_CNT;
          sclk_next = ~sclk_reg;
          if (!sclk_reg) begin
            misoBit_next = miso; // sample on rising edge
          end else begin
            shift_next = {shift_reg[6:0], misoBit_reg}; // shift on falling edge
          end
          if (half_reg == HALF_LAST) begin
            state_next = ENG_IDLE;
            rx_next = shift_next;
            done_next = 1'b1;
          end else begin
            half_next = half_reg + 5'h1;
          end
        end
      end
      default: state_next = ENG_IDLE;
    endcase
  end

  // registers
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_reg <= ENG_IDLE;
      shift_reg <= 8'h00;
      rx_reg <= 8'h00;
      half_reg <= 5'h0;
      tick_reg <= 8'h00;
      sclk_reg <= 1'b0;
      done_reg <= 1'b0;
      misoBit_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      shift_reg <= shift_next;
      rx_reg <= rx_next;
      half_reg <= half_next;
      tick_reg <= tick_next;
      sclk_reg <= sclk_next;
      done_reg <= done_next;
      misoBit_reg <= misoBit_next;
    end
  end

  // outputs
  assign busy = (state_reg == ENG_SHIFT);
  assign done = done_reg;
  assign rxByte = rx_reg;
  assign sclk = sclk_reg;
  assign mosi = shift_reg[7];

endmodule : byte_shifter

// ===== hw/spi_status_flags.sv
// serial master status/flag block with APB register slave and byte engine
// assumes: APB3 master, single clock, flags cleared by status read then data access
//
// What this block does
// - transfer-done flag lives in status bit 7
// - byte exchange finishing sets transfer-done flag
// - irq while done flag and irq enable
// - status read seeing flag, then data access clears
// - data writes refused until armed status read
// - write-clash flag lives in status bit 6
// - data write during transfer sets clash flag
// - colliding write discarded, transfer untouched
// - status read seeing clash, then data access clears
// - status resets to 0x80
// - exchange starts only on master data write
//
// The implementer's own choices: the register offsets and register access over APB.
`timescale 1ns/1ps
module spi_status_flags
  import spi_flags_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // interrupt
  output logic irqOut,
  // serial pins
  output logic sclk,
  output logic mosi,
  input wire logic miso
);

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------

  // true when the offset names a mapped register
  function automatic logic isMapped(input logic [7:0] a);
    if (a == OFF_STATUS) isMapped = 1'b1;
    else if (a == OFF_DATA) isMapped = 1'b1;
    else if (a == OFF_CTRL) isMapped = 1'b1;
    else if (a == OFF_EVSTAT) isMapped = 1'b1;
    else if (a == OFF_EVMASK) isMapped = 1'b1;
    else isMapped = 1'b0;
  endfunction : isMapped

  logic setupPh, accessPh, statusRd, dataAcc, dataWr, ctrlWr, evStatWr, evMaskWr;

  // apb phases; writes and read side effects take effect only in the access phase
  assign setupPh = psel && !penable;
  assign accessPh = psel && penable;
  assign statusRd = accessPh && !pwrite && (paddr == OFF_STATUS);
  assign dataAcc = accessPh && (paddr == OFF_DATA);
  assign dataWr = dataAcc && pwrite;
  assign ctrlWr = accessPh && pwrite && (paddr == OFF_CTRL);
  assign evStatWr = accessPh && pwrite && (paddr == OFF_EVSTAT);
  assign evMaskWr = accessPh && pwrite && (paddr == OFF_EVMASK);
  assign pready = 1'b1;
  assign pslverr = accessPh && !isMapped(paddr);

  // ----------------------------------------------------------------
  // flag and control state
  // ----------------------------------------------------------------

  logic done_reg, done_next;
  logic clash_reg, clash_next;
  logic doneArm_reg, doneArm_next;
  logic clashArm_reg, clashArm_next;
  ctrl_s ctrl_reg, ctrl_next;
  logic [1:0] evStat_reg, evStat_next;
  logic [1:0] evMask_reg, evMask_next;
  logic [31:0] prdata_reg, prdata_next;
  logic engStart, engBusy, engDone;
  logic [7:0] engRx;
  status_s statusView;

  // status image; reserved bits always zero
  always_comb begin
    statusView = '0;
    statusView.done = done_reg;
    statusView.clash = clash_reg;
  end

  // a data write starts an exchange only when master, idle and not inhibited
  assign engStart = dataWr && ctrl_reg.master && !engBusy
    && !(done_reg && !doneArm_reg);

  // next values for flags, arms, control and event registers
  always_comb begin
    done_next = done_reg;
    clash_next = clash_reg;
    doneArm_next = doneArm_reg;
    clashArm_next = clashArm_reg;
    ctrl_next = ctrl_reg;
    evStat_next = evStat_reg;
    evMask_next = evMask_reg;
    // status read arms the clear for whichever flag it returned set
    if (statusRd && prdata_reg[BIT_DONE]) begin
      doneArm_next = 1'b1;
    end
    if (statusRd && prdata_reg[BIT_CLASH]) begin
      clashArm_next = 1'b1;
    end
    // armed data access clears the flag
    if (dataAcc && doneArm_reg) begin
      done_next = 1'b0;
      doneArm_next = 1'b0;
    end
    if (dataAcc && clashArm_reg) begin
      clash_next = 1'b0;
      clashArm_next = 1'b0;
    end
    // hardware sets win over clears in the same cycle
    if (engDone) begin
      done_next = 1'b1;
      doneArm_next = 1'b0;
    end
    if (dataWr && engBusy) begin
      clash_next = 1'b1;
      clashArm_next = 1'b0;
    end
    // control and mask writes
    if (ctrlWr) begin
      ctrl_next.irqEnable = pwdata[BIT_IRQEN];
      ctrl_next.master = pwdata[BIT_MASTER];
    end
    if (evMaskWr) begin
      evMask_next = pwdata[1:0];
    end
    // sticky events, write one to clear, set wins
    if (evStatWr) begin
      evStat_next = evStat_reg & ~pwdata[1:0];
    end
    if (engDone) begin
      evStat_next[EV_DONE] = 1'b1;
    end
    if (dataWr && engBusy) begin
      evStat_next[EV_CLASH] = 1'b1;
    end
  end

  // read data is captured in the setup phase and held through access
  always_comb begin
    prdata_next = prdata_reg;
    if (setupPh && !pwrite) begin
      if (paddr == OFF_STATUS) prdata_next = {24'h00_0000, statusView};
      else if (paddr == OFF_DATA) prdata_next = {24'h00_0000, engRx};
      else if (paddr == OFF_CTRL) prdata_next = {30'h0000_0000, ctrl_reg};
      else if (paddr == OFF_EVSTAT) prdata_next = {30'h0000_0000, evStat_reg};
      else if (paddr == OFF_EVMASK) prdata_next = {30'h0000_0000, evMask_reg};
      else prdata_next = 32'h0000_0000;
    end
  end

  // registers
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      done_reg <= STATUS_RESET[BIT_DONE];
      clash_reg <= STATUS_RESET[BIT_CLASH];
      doneArm_reg <= 1'b0;
      clashArm_reg <= 1'b0;
      ctrl_reg <= CTRL_RESET;
      evStat_reg <= EV_RESET;
      evMask_reg <= EV_RESET;
      prdata_reg <= 32'h0000_0000;
    end else begin
      done_reg <= done_next;
      clash_reg <= clash_next;
      doneArm_reg <= doneArm_next;
      clashArm_reg <= clashArm_next;
      ctrl_reg <= ctrl_next;
      evStat_reg <= evStat_next;
      evMask_reg <= evMask_next;
      prdata_reg <= prdata_next;
    end
  end

  assign prdata = prdata_reg;

  // serial interrupt request plus masked sticky events
  assign irqOut = (done_reg && ctrl_reg.irqEnable)
    || |(evStat_reg & evMask_reg);

  // ----------------------------------------------------------------
  // byte engine
  // ----------------------------------------------------------------

  byte_shifter u_shifter (
    .clock(clock),
    .rst(rst),
    .start(engStart),
    .txByte(pwdata[7:0]),
    .busy(engBusy),
    .done(engDone),
    .rxByte(engRx),
    .sclk(sclk),
    .mosi(mosi),
    .miso(miso)
  );

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence sArmedDone;
    doneArm_reg && !engDone;
  endsequence

  sequence sDataTouch;
    dataAcc;
  endsequence

  a_done_sets: assert property (engDone |=> done_reg)
    else $error("done flag not set after exchange end");

  a_irq_level: assert property (done_reg && ctrl_reg.irqEnable |-> irqOut)
    else $error("irq missing while done flag and enable");

  a_done_clears: assert property ((sArmedDone and sDataTouch) |=> !done_reg)
    else $error("armed data access did not clear done flag");

  a_done_holds: assert property (done_reg && !doneArm_reg && !statusRd |=> done_reg)
    else $error("done flag cleared without armed status read");

  a_write_refused: assert property (dataWr && done_reg && !doneArm_reg |-> !engStart)
    else $error("data write accepted while inhibited");

  a_clash_sets: assert property (dataWr && engBusy
    |=> clash_reg ##0 (engBusy || engDone))
    else $error("clash flag not set by write during transfer");

  a_clash_no_restart: assert property (dataWr && engBusy |-> !engStart)
    else $error("colliding write reached the engine");

  a_clash_clears: assert property (clashArm_reg && dataAcc && !(dataWr && engBusy)
    |=> !clash_reg)
    else $error("armed data access did not clear clash flag");

  a_start_master: assert property (engStart |-> ctrl_reg.master ##1 engBusy)
    else $error("exchange started without master or did not run");

  a_rsvd_zero: assert property (statusRd
    |-> prdata_reg[5:0] == 6'h00 && prdata_reg[31:8] == 24'h00_0000)
    else $error("reserved status bits not zero");

  a_status_bits: assert property (setupPh && !pwrite && paddr == OFF_STATUS
    |=> prdata_reg[7] == $past(done_reg) && prdata_reg[6] == $past(clash_reg))
    else $error("status image wrong");

endmodule : spi_status_flags

// ===== tb/serial_dev_model.sv
// serial device model: answers each byte exchange with a reply byte
// assumes: mode 0, msb first, sclk idles low between bytes
`timescale 1ns/1ps
module serial_dev_model (
  // reset
  input wire logic rst,
  // serial pins
  input wire logic sclk,
  input wire logic mosi,
  output logic miso,
  // bench side
  input wire logic [7:0] reply,
  output logic [7:0] rxByte,
  output int frames
);
  // ----------------------------------------
  // shifting
  // ----------------------------------------
  logic [7:0] sh;
  int cnt;
  // first bit of each byte is presented before the first rising edge
  assign miso = (cnt == 0) ? reply[7] : sh[7];
  // capture on the rising serial edge
  always @(posedge sclk) begin
    rxByte <= {rxByte[6:0], mosi};
  end
  // shift on the falling edge and count whole bytes
  always @(negedge sclk or posedge rst) begin
    if (rst) begin
      cnt <= 0;
      frames <= 0;
      sh <= 8'h00;
    end else begin
      sh <= (cnt == 0) ? {reply[6:0], 1'b0} : {sh[6:0], 1'b0};
      cnt <= (cnt + 1) % 8;
      if (cnt == 7) frames <= frames + 1;
    end
  end
endmodule : serial_dev_model

// ===== tb/spi_status_flags_tb.sv
// bench for the serial status/flag block: apb master, flag model, checks
// assumes: zero wait state apb slave, serial device model on the pins
`timescale 1ns/1ps
module spi_status_flags_tb;
  import spi_flags_pkg::*;
  // ----------------------------------------
  // signals and model state
  // ----------------------------------------
  logic clock = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic pready, pslverr, irqOut, sclk, mosi, miso, err;
  logic [7:0] paddr = 8'h00, reply = 8'h00, devRx, txExp, rxExp;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rdv;
  int bad_count = 0, n_compared = 0, frames, seed = 32'hd887;
  int done = 1, clash = 0, armD = 0, armC = 0, irqEn = 0, master = 1;
  int ev = 0, mask = 0, busy = 0;
  // 200 MHz clock
  always #2.5 clock = ~clock;
  spi_status_flags dut (.clock(clock), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irqOut(irqOut), .sclk(sclk), .mosi(mosi), .miso(miso));
  serial_dev_model dev (.rst(rst), .sclk(sclk), .mosi(mosi), .miso(miso), .reply(reply),
    .rxByte(devRx), .frames(frames));
  // compare and count
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // verdict and end of run
  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : stop_test
  // one apb transfer, one idle cycle after it
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rdv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask : xfer
  // armed flags drop on a data access
  task automatic clearArmed();
    if (armD) done = 0;
    if (armC) clash = 0;
    armD = 0;
    armC = 0;
  endtask : clearArmed
  // read, compare with the model, update arming
  task automatic rd(input logic [7:0] a, input string what);
    logic [31:0] e;
    xfer(1'b0, a, 32'h0000_0000);
    case (a)
      OFF_STATUS: e = {24'h0, done[0], clash[0], 6'h00};
      OFF_DATA: e = {24'h0, rxExp};
      OFF_CTRL: e = {30'h0, master[0], irqEn[0]};
      OFF_EVSTAT: e = ev;
      OFF_EVMASK: e = mask;
      default: e = 32'h0000_0000;
    endcase
    check(what, rdv, e);
    check("pslverr", {31'h0, err}, {31'h0, a > OFF_EVMASK});
    if (a == OFF_STATUS) begin
      armD = armD | done;
      armC = armC | clash;
    end
    if (a == OFF_DATA) clearArmed();
  endtask : rd
  // write and apply to the model
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int hit, go;
    xfer(1'b1, a, d);
    check("pslverr", {31'h0, err}, {31'h0, a > OFF_EVMASK});
    hit = busy;
    go = !busy && master && (!done || armD);
    case (a)
      OFF_CTRL: begin
        master = d[1];
        irqEn = d[0];
      end
      OFF_EVSTAT: ev = ev & ~int'(d[1:0]);
      OFF_EVMASK: mask = d[1:0];
      OFF_DATA: begin
        clearArmed();
        if (hit) begin
          clash = 1;
          ev = ev | 2;
        end
        if (go) begin
          busy = 1;
          txExp = d[7:0];
        end
      end
      default: ;
    endcase
  endtask : wr
  // interrupt level against the model
  task automatic irqChk();
    @(negedge clock);
    check("irq", {31'h0, irqOut}, {31'h0, ((done & irqEn) | (ev & mask)) != 0});
    @(posedge clock);
  endtask : irqChk
  // wait for the done event through the masked interrupt
  task automatic waitDone();
    int n;
    n = 0;
    do begin
      @(negedge clock);
      n++;
    end while (irqOut !== 1'b1 && n < 400);
    check("frame end irq", {31'h0, irqOut}, 32'h0000_0001);
    @(posedge clock);
    done = 1;
    armD = 0;
    ev = ev | 1;
    busy = 0;
    rxExp = reply;
    check("device rx", {24'h0, devRx}, {24'h0, txExp});
  endtask : waitDone
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    wr(OFF_DATA, 32'h0000_00a5);
    repeat (40) @(posedge clock);
    check("frames", frames, 0);
    wr(OFF_STATUS, 32'hffff_ffff);
    rd(OFF_STATUS, "status");
    rd(OFF_CTRL, "ctrl");
    rd(8'h20, "unmapped");
    wr(OFF_EVMASK, 32'h0000_0001);
    rd(OFF_EVMASK, "mask");
    for (int i = 0; i < 4; i++) begin
      reply <= 8'($random(seed));
      if (i == 1) wr(OFF_CTRL, 32'h0000_0003);
      wr(OFF_DATA, {24'h0, 8'($random(seed))});
      rd(OFF_STATUS, "busy status");
      if (i % 2 == 0) wr(OFF_DATA, 32'h0000_005a);
      rd(OFF_STATUS, "clash status");
      waitDone();
      rd(OFF_EVSTAT, "events");
      wr(OFF_EVSTAT, 32'h0000_0003);
      irqChk();
      rd(OFF_STATUS, "done status");
      rd(OFF_DATA, "rx byte");
      irqChk();
      rd(OFF_STATUS, "cleared status");
    end
    wr(OFF_CTRL, 32'h0000_0000);
    wr(OFF_DATA, 32'h0000_0033);
    repeat (40) @(posedge clock);
    check("frames", frames, 4);
    rd(OFF_STATUS, "idle status");
    stop_test();
  end
  // hang guard, well beyond the expected run
  initial begin
    #50000;
    bad_count++;
    $display("ERROR watchdog expected finish seen hang");
    stop_test();
  end
endmodule : spi_status_flags_tb
